// File: key_pad_model.sv
`timescale 1ns/1ps
// ==========================================================
// keypad switches on port pins, pulled up when released
module key_pad_model (
  input  wire logic       REF_CLK,  // cpu clock
  output logic      [7:0] port_lvl  // pin levels
);
  logic [7:0] key_down;  // pressed keys pull pins low

  // released pins float to the pull-up level, never hold a stale value
  assign port_lvl = ~key_down;

  initial begin
    key_down = 8'h00;
  end

  // hold keys for a chosen number of edges, then let go
  task automatic press(input logic [7:0] keys, input int cycles);
    @(posedge REF_CLK);
    key_down <= keys;
    repeat (cycles) @(posedge REF_CLK);
    key_down <= 8'h00;
  endtask
endmodule // key_pad_model

// File: kmi_pkg.sv
package kmi_pkg;
  // ==========================================================
  // register map: printed offsets are indices, byte address = 4 * index
  localparam int          ADDR_W         = 12;
  localparam logic [7:0]  MASK_IDX       = 8'h86;
  localparam logic [7:0]  PATTERN_IDX    = 8'h93;
  localparam logic [7:0]  CONTROL_IDX    = 8'h94;
  localparam logic [7:0]  IRQ_EN_IDX     = 8'hA0;
  localparam logic [7:0]  EVT_STAT_IDX   = 8'hA1;
  localparam logic [7:0]  EVT_MASK_IDX   = 8'hA2;
  // ==========================================================
  // field positions and values after reset
  localparam int          FLAG_BIT       = 0;
  localparam int          POLARITY_BIT   = 1;
  localparam int          KBI_EN_BIT     = 0;
  localparam int          GLB_EN_BIT     = 1;
  localparam logic [7:0]  IMPL_BITS      = 8'h06;
  localparam logic [7:0]  MASK_RST       = 8'h00;
  localparam logic [7:0]  PATTERN_RST    = 8'h06;
  // ==========================================================
  // match must persist this many cycles, i.e. more than six
  localparam logic [2:0]  MATCH_HOLD_CYCLES = 3'h7;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  // ==========================================================
  // sticky event bits
  typedef struct packed {
    logic wake;
    logic match;
  } evt_t;
  localparam evt_t        EVT_RST        = '0;
endpackage

// File: port_pattern_match_interrupt.sv
`timescale 1ns/1ps
// Operation
// R1: mask register picks participating port pins
// R2: port continuously compared with pattern register
// R3: polarity one means equal, zero unequal
// R4: flag sets when masked condition holds
// R5: software clears flag by writing zero
// R6: irq while flag, local and global enable
// R7: match must persist over six clocks
// R8: enabled match wakes from idle, power-down
// R9: all-ones pattern, unequal: any key triggers
// R10: pattern bits 1,2 only, reset one
// R11: mask bits 1,2 only, reset zero
// R12: mask effective only while block enabled
// R13: unmasked bits never create or prevent match; with the block disabled the code compares them too
// R14: port synchronised before comparison
module port_pattern_match_interrupt
  import kmi_pkg::*;
(
  input  wire logic              REF_CLK,        // 125 MHz
  input  wire logic              RESET,          // sync, active high
  input  wire logic [7:0]        PORT_IN,        // port pin levels
  input  wire logic              IDLE_MODE,      // cpu in idle
  input  wire logic              POWER_DOWN,     // cpu in power-down
  output logic                   KEY_IRQ,        // match interrupt request
  output logic                   WAKE,           // wake request
  output logic                   EVT_IRQ,        // status/mask interrupt
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,   // write address
  input  wire logic              S_AXI_AWVALID,  // write address valid
  output logic                   S_AXI_AWREADY,  // write address ready
  input  wire logic [31:0]       S_AXI_WDATA,    // write data
  input  wire logic [3:0]        S_AXI_WSTRB,    // byte strobes
  input  wire logic              S_AXI_WVALID,   // write data valid
  output logic                   S_AXI_WREADY,   // write data ready
  output logic [1:0]             S_AXI_BRESP,    // write response
  output logic                   S_AXI_BVALID,   // write response valid
  input  wire logic              S_AXI_BREADY,   // write response ready
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,   // read address
  input  wire logic              S_AXI_ARVALID,  // read address valid
  output logic                   S_AXI_ARREADY,  // read address ready
  output logic [31:0]            S_AXI_RDATA,    // read data
  output logic [1:0]             S_AXI_RRESP,    // read response
  output logic                   S_AXI_RVALID,   // read data valid
  input  wire logic              S_AXI_RREADY    // read data ready
);

  // ==========================================================
  // state
  logic [7:0]  sync1;
  logic [7:0]  sync2;
  logic [7:0]  key_match_mask;
  logic [7:0]  key_match_pattern;
  logic        match_polarity_select;
  logic        key_match_flag;
  logic        key_match_irq_enable;
  logic        global_irq_enable;
  evt_t        evt_stat;
  evt_t        evt_mask;
  logic [2:0]  hold_cnt;
  logic [7:0]  aw_idx;
  logic        aw_ok;
  logic [7:0]  wdata;
  logic        wlane;

  // ==========================================================
  // port synchroniser; only sync2 is looked at
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      sync1 <= 8'hFF;
      sync2 <= 8'hFF;
    end else begin
      sync1 <= PORT_IN;                                        // [R14]
      sync2 <= sync1;                                          // [R14]
    end
  end

  // ==========================================================
  // match decode
  logic [7:0]  eff_mask;
  logic [7:0]  diff;
  logic        equal;
  logic        match;
  logic        held;
  logic [2:0]  next_hold_cnt;
  // disabled block compares all implemented pins, mask ignored
  assign eff_mask = (key_match_irq_enable ? key_match_mask : IMPL_BITS)
                    & IMPL_BITS;                               // [R1] [R12]
  assign diff  = (sync2 ^ key_match_pattern) & eff_mask;       // [R2] [R13]
  assign equal = (diff == 8'h00);
  // empty mask never matches, so equal cannot fire vacuously
  assign match = (|eff_mask) &&
                 (match_polarity_select ? equal : !equal);     // [R3] [R9]
  assign held  = match && (hold_cnt >= MATCH_HOLD_CYCLES - 3'h1); // [R7]
  assign next_hold_cnt = !match ? 3'h0 :
                         (hold_cnt == MATCH_HOLD_CYCLES) ? hold_cnt :
                         hold_cnt + 3'h1;

  // ==========================================================
  // bus decode
  logic        wr_commit;
  logic        wr_ctl;
  logic        flag_clr;
  logic [7:0]  ar_idx;
  logic        ar_ok;
  logic [7:0]  rd_data;
  logic        rd_hit;
  logic        wr_hit;
  assign wr_commit = !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;
  assign wr_ctl    = wr_commit && aw_ok && wlane && (aw_idx == CONTROL_IDX);
  assign flag_clr  = wr_ctl && !wdata[FLAG_BIT];               // [R5]
  assign ar_idx    = S_AXI_ARADDR[9:2];
  assign ar_ok     = (S_AXI_ARADDR[ADDR_W-1:10] == '0);
  assign rd_hit    = ar_ok && (ar_idx == MASK_IDX || ar_idx == PATTERN_IDX ||
                     ar_idx == CONTROL_IDX || ar_idx == IRQ_EN_IDX ||
                     ar_idx == EVT_STAT_IDX || ar_idx == EVT_MASK_IDX);
  assign wr_hit    = aw_ok && (aw_idx == MASK_IDX || aw_idx == PATTERN_IDX ||
                     aw_idx == CONTROL_IDX || aw_idx == IRQ_EN_IDX ||
                     aw_idx == EVT_STAT_IDX || aw_idx == EVT_MASK_IDX);
  // reserved bits read as zero
  assign rd_data =
    !ar_ok                      ? 8'h00 :
    (ar_idx == MASK_IDX)        ? key_match_mask :
    (ar_idx == PATTERN_IDX)     ? key_match_pattern :
    (ar_idx == CONTROL_IDX)     ? {6'h00, match_polarity_select, key_match_flag} :
    (ar_idx == IRQ_EN_IDX)      ? {6'h00, global_irq_enable, key_match_irq_enable} :
    (ar_idx == EVT_STAT_IDX)    ? {6'h00, evt_stat} :
    (ar_idx == EVT_MASK_IDX)    ? {6'h00, evt_mask} : 8'h00;

  // ==========================================================
  // flag and events; a new match outranks a clearing write
  logic        next_flag;
  logic        wake_cond;
  evt_t        ev;
  assign next_flag = held || (key_match_flag && !flag_clr);    // [R4] [R5] [R7]
  assign wake_cond = key_match_flag && key_match_irq_enable &&
                     (IDLE_MODE || POWER_DOWN);                // [R8]
  assign ev.match  = held && !key_match_flag;
  assign ev.wake   = wake_cond && !WAKE;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      hold_cnt       <= 3'h0;
      key_match_flag <= 1'b0;
      KEY_IRQ        <= 1'b0;
      WAKE           <= 1'b0;
      EVT_IRQ        <= 1'b0;
    end else begin
      hold_cnt       <= next_hold_cnt;                         // [R7]
      key_match_flag <= next_flag;
      KEY_IRQ        <= key_match_flag && key_match_irq_enable
                        && global_irq_enable;                  // [R6]
      WAKE           <= wake_cond;                             // [R8]
      EVT_IRQ        <= |(evt_stat & evt_mask);
    end
  end

  // ==========================================================
  // register writes; w1c status, set wins
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      key_match_mask        <= MASK_RST;                       // [R11]
      key_match_pattern     <= PATTERN_RST;                    // [R10]
      match_polarity_select <= 1'b0;
      key_match_irq_enable  <= 1'b0;
      global_irq_enable     <= 1'b0;
      evt_stat              <= EVT_RST;
      evt_mask              <= EVT_RST;
    end else begin
      evt_stat <= (evt_stat & ~((wr_commit && aw_ok && wlane &&
                  aw_idx == EVT_STAT_IDX) ? evt_t'(wdata[1:0]) : EVT_RST)) | ev;
      if (wr_commit && aw_ok && wlane) begin
        unique case (aw_idx)
          MASK_IDX:     key_match_mask    <= wdata & IMPL_BITS; // [R11]
          PATTERN_IDX:  key_match_pattern <= wdata & IMPL_BITS; // [R10]
          CONTROL_IDX:  match_polarity_select <= wdata[POLARITY_BIT];
          IRQ_EN_IDX: begin
            key_match_irq_enable <= wdata[KBI_EN_BIT];
            global_irq_enable    <= wdata[GLB_EN_BIT];
          end
          EVT_MASK_IDX: evt_mask <= evt_t'(wdata[1:0]);
          default:      ;
        endcase
      end
    end
  end

  // ==========================================================
  // axi write channels; one write at a time
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= RESP_OKAY;
      aw_idx        <= 8'h00;
      aw_ok         <= 1'b0;
      wdata         <= 8'h00;
      wlane         <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        S_AXI_AWREADY <= 1'b0;
        aw_idx        <= S_AXI_AWADDR[9:2];
        aw_ok         <= (S_AXI_AWADDR[ADDR_W-1:10] == '0);
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        S_AXI_WREADY <= 1'b0;
        wdata        <= S_AXI_WDATA[7:0];
        wlane        <= S_AXI_WSTRB[0];
      end
      if (wr_commit) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // axi read channels
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= {24'h00_0000, rd_data};
      S_AXI_RRESP   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // ==========================================================
  // assertions
  property p_flag_needs_hold;
    @(posedge REF_CLK) disable iff (RESET)
    $rose(key_match_flag) |-> $past(match, 1) && $past(match, 7);
  endproperty
  a_flag_needs_hold: assert property (p_flag_needs_hold) // [R7]
    else $error("flag rose without seven matching cycles");

  property p_short_ignored;
    @(posedge REF_CLK) disable iff (RESET)
    (!key_match_flag && !match) ##1 (match && !key_match_flag)[*6] ##1 !match
    |=> !key_match_flag;
  endproperty
  a_short_ignored: assert property (p_short_ignored) // [R7]
    else $error("six-cycle match set the flag");

  property p_sets_after_hold;
    @(posedge REF_CLK) disable iff (RESET)
    match[*7] |=> key_match_flag;
  endproperty
  a_sets_after_hold: assert property (p_sets_after_hold) // [R4]
    else $error("persistent match did not set flag");

  property p_sticky;
    @(posedge REF_CLK) disable iff (RESET)
    key_match_flag && !flag_clr |=> key_match_flag;
  endproperty
  a_sticky: assert property (p_sticky) // [R5]
    else $error("flag dropped without clearing write");

  property p_clear;
    @(posedge REF_CLK) disable iff (RESET)
    flag_clr && !held |=> !key_match_flag;
  endproperty
  a_clear: assert property (p_clear) // [R5]
    else $error("clearing write ignored");

  property p_irq;
    @(posedge REF_CLK) disable iff (RESET)
    (key_match_flag && key_match_irq_enable && global_irq_enable)[*2]
    |-> KEY_IRQ;
  endproperty
  a_irq: assert property (p_irq) // [R6]
    else $error("interrupt missing while enabled flag set");

  property p_no_irq;
    @(posedge REF_CLK) disable iff (RESET)
    !global_irq_enable |=> !KEY_IRQ;
  endproperty
  a_no_irq: assert property (p_no_irq) // [R6]
    else $error("interrupt while globally disabled");

  property p_wake;
    @(posedge REF_CLK) disable iff (RESET)
    key_match_flag && key_match_irq_enable && (IDLE_MODE || POWER_DOWN)
    |=> WAKE;
  endproperty
  a_wake: assert property (p_wake) // [R8]
    else $error("no wake from low power mode");

  property p_unmasked;
    @(posedge REF_CLK) disable iff (RESET)
    key_match_irq_enable && ((key_match_mask & IMPL_BITS) == 8'h00) |-> !match;
  endproperty
  a_unmasked: assert property (p_unmasked) // [R13]
    else $error("match with no pin enabled");

  property p_impl_bits;
    @(posedge REF_CLK) disable iff (RESET)
    ((key_match_pattern | key_match_mask) & ~IMPL_BITS) == 8'h00;
  endproperty
  a_impl_bits: assert property (p_impl_bits) // [R10] [R11]
    else $error("reserved pattern or mask bit set");

  c_flag_set: cover property (@(posedge REF_CLK) disable iff (RESET)
    $rose(key_match_flag));
  c_irq: cover property (@(posedge REF_CLK) disable iff (RESET) $rose(KEY_IRQ));
  c_wake: cover property (@(posedge REF_CLK) disable iff (RESET) $rose(WAKE));
  c_clear: cover property (@(posedge REF_CLK) disable iff (RESET)
    flag_clr ##1 !key_match_flag);

endmodule // port_pattern_match_interrupt

// File: test_port_pattern_match_interrupt.sv
`timescale 1ns/1ps
// ==========================================================
// register-level bench for the pattern-match block
module test_port_pattern_match_interrupt;
  import kmi_pkg::*;
  logic REF_CLK, RESET, IDLE_MODE, POWER_DOWN;
  logic awv, wv, bready, arv, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rd;
  logic [3:0] wstrb;
  logic [1:0] rs, ws;
  wire logic [7:0] port;
  wire logic key_irq, wake, evt_irq, awr, wr, bv, arr, rv;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int bad_count, checks_done, cycles;

  key_pad_model key_pad_model_i (.REF_CLK(REF_CLK), .port_lvl(port));
  port_pattern_match_interrupt port_pattern_match_interrupt_i (
    .REF_CLK(REF_CLK), .RESET(RESET), .PORT_IN(port), .IDLE_MODE(IDLE_MODE),
    .POWER_DOWN(POWER_DOWN), .KEY_IRQ(key_irq), .WAKE(wake), .EVT_IRQ(evt_irq),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready));

  initial begin
    REF_CLK = 1'b0;
    forever #4 REF_CLK = ~REF_CLK;
  end

  // ==========================================================
  // closing report, also reached by the hang limit
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge REF_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // ==========================================================
  // bus tasks: handshakes judged at the falling edge, where all is settled
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] val, input logic [3:0] st);
    logic a, w, b;
    b = 1'b0;
    @(posedge REF_CLK);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h0, val};
    wstrb <= st;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    while (!b) begin
      @(negedge REF_CLK);
      a = awv & awr;
      w = wv & wr;
      b = bv;
      ws = bresp;
      @(posedge REF_CLK);
      if (a) awv <= 1'b0;
      if (w) wv <= 1'b0;
      if (b) bready <= 1'b0;
    end
  endtask

  task automatic rd_reg(input logic [7:0] idx);
    logic a, r;
    r = 1'b0;
    @(posedge REF_CLK);
    araddr <= {2'h0, idx, 2'h0};
    arv <= 1'b1;
    rready <= 1'b1;
    while (!r) begin
      @(negedge REF_CLK);
      a = arv & arr;
      r = rv;
      rd = rdata;
      rs = rresp;
      @(posedge REF_CLK);
      if (a) arv <= 1'b0;
      if (r) rready <= 1'b0;
    end
  endtask

  task automatic rd_chk(input string name, input logic [7:0] idx, input logic [7:0] exp);
    rd_reg(idx);
    check(name, {24'h0, exp}, rd);
    check("rresp", {30'h0, RESP_OKAY}, {30'h0, rs});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge REF_CLK);
    @(negedge REF_CLK);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {bad_count, checks_done, cycles} = '0;
    {awv, wv, bready, arv, rready, IDLE_MODE, POWER_DOWN} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    RESET = 1'b1;
    repeat (10) @(posedge REF_CLK);
    RESET <= 1'b0;
    rd_chk("mask rst", MASK_IDX, MASK_RST);
    rd_chk("pattern rst", PATTERN_IDX, PATTERN_RST);
    rd_chk("control rst", CONTROL_IDX, 8'h00);
    wr_reg(PATTERN_IDX, 8'hF9, 4'hF);
    check("write resp", {30'h0, RESP_OKAY}, {30'h0, ws});
    rd_chk("pattern rsvd", PATTERN_IDX, 8'h00);
    wr_reg(PATTERN_IDX, 8'hFF, 4'hF);
    rd_chk("pattern rw", PATTERN_IDX, 8'h06);
    wr_reg(MASK_IDX, 8'hFF, 4'hF);
    rd_chk("mask rw", MASK_IDX, 8'h06);
    rd_reg(8'h10);
    check("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    check("unmapped data", 32'h0, rd);
    wr_reg(8'h10, 8'hFF, 4'hF);
    check("unmapped wr resp", {30'h0, RESP_SLVERR}, {30'h0, ws});
    // zero pattern above stood long enough to match; start the next test clean
    wr_reg(CONTROL_IDX, 8'h00, 4'hF);
    rd_chk("flag pre", CONTROL_IDX, 8'h00);
    // block disabled: mask ignored, both pins compared
    wr_reg(MASK_IDX, 8'h02, 4'hF);
    key_pad_model_i.press(8'h04, 10);
    settle(12);
    rd_chk("flag mask off", CONTROL_IDX, 8'h01);
    check("irq disabled", 32'h0, {31'h0, key_irq});
    wr_reg(CONTROL_IDX, 8'h00, 4'hF);
    rd_chk("flag cleared", CONTROL_IDX, 8'h00);
    // enabled: masked-out pin cannot match, short press refused
    wr_reg(IRQ_EN_IDX, 8'h03, 4'hF);
    key_pad_model_i.press(8'h04, 10);
    settle(12);
    rd_chk("masked pin", CONTROL_IDX, 8'h00);
    key_pad_model_i.press(8'h02, 6);
    settle(12);
    rd_chk("six cycles", CONTROL_IDX, 8'h00);
    key_pad_model_i.press(8'h02, 7);
    settle(12);
    rd_chk("seven cycles", CONTROL_IDX, 8'h01);
    wr_reg(CONTROL_IDX, 8'h01, 4'hF);
    rd_chk("write one keeps", CONTROL_IDX, 8'h01);
    check("key irq", 32'h1, {31'h0, key_irq});
    IDLE_MODE <= 1'b1;
    settle(2);
    check("wake idle", 32'h1, {31'h0, wake});
    IDLE_MODE <= 1'b0;
    POWER_DOWN <= 1'b1;
    settle(2);
    check("wake pd", 32'h1, {31'h0, wake});
    POWER_DOWN <= 1'b0;
    wr_reg(IRQ_EN_IDX, 8'h01, 4'hF);
    settle(2);
    check("global off", 32'h0, {31'h0, key_irq});
    wr_reg(CONTROL_IDX, 8'h00, 4'h0);
    rd_chk("strobe off", CONTROL_IDX, 8'h01);
    wr_reg(CONTROL_IDX, 8'h00, 4'hF);
    // event status, mask and shared interrupt
    rd_chk("evt status", EVT_STAT_IDX, 8'h03);
    check("evt masked", 32'h0, {31'h0, evt_irq});
    wr_reg(EVT_MASK_IDX, 8'h01, 4'hF);
    settle(2);
    check("evt irq", 32'h1, {31'h0, evt_irq});
    wr_reg(EVT_STAT_IDX, 8'h03, 4'hF);
    settle(2);
    check("evt cleared", 32'h0, {31'h0, evt_irq});
    // equal polarity, first with one pin left out of the compare, then with both pins in
    wr_reg(PATTERN_IDX, 8'h02, 4'hF);
    wr_reg(CONTROL_IDX, 8'h02, 4'hF);
    settle(12);
    rd_chk("equal match", CONTROL_IDX, 8'h03);
    wr_reg(MASK_IDX, 8'h06, 4'hF);
    wr_reg(CONTROL_IDX, 8'h02, 4'hF);
    settle(12);
    rd_chk("equal miss", CONTROL_IDX, 8'h02);
    // enabled with an empty mask: no pin may raise the flag
    wr_reg(MASK_IDX, 8'h00, 4'hF);
    wr_reg(CONTROL_IDX, 8'h00, 4'hF);
    key_pad_model_i.press(8'h06, 10);
    settle(12);
    rd_chk("empty mask", CONTROL_IDX, 8'h00);
    test_done();
  end
endmodule // test_port_pattern_match_interrupt
